/* File: inc/upef_defs.vh */
// register offsets, field positions and reset values for the upstream error forwarding block
`ifndef UPEF_DEFS_VH
`define UPEF_DEFS_VH
// register byte offsets
`define UPEF_CTRL_OFS 12'h000
`define UPEF_SEC_STAT_OFS 12'h004
`define UPEF_PRI_STAT_OFS 12'h008
`define UPEF_UNC_STAT_OFS 12'h00C
`define UPEF_UNC_MASK_OFS 12'h010
`define UPEF_UNC_SEV_OFS 12'h014
`define UPEF_FIRST_ERROR_POINTER_OFS 12'h018
`define UPEF_HDR_LOG_OFS 12'h01C
`define UPEF_DEV_STAT_OFS 12'h020
`define UPEF_IRQ_STAT_OFS 12'h024
`define UPEF_IRQ_MASK_OFS 12'h028
// control register fields
`define UPEF_CTRL_PERESP 0
`define UPEF_CTRL_MAMODE 1
`define UPEF_CTRL_SYSTEM_ERROR_REPORT_ENABLE 2
`define UPEF_CTRL_FTL_EN 3
`define UPEF_CTRL_NFTL_EN 4
`define UPEF_CTRL_RST 5'h00
// secondary status fields
`define UPEF_SS_DPE 0
`define UPEF_SS_MDP 1
`define UPEF_SS_STA 2
`define UPEF_SS_RMA 3
`define UPEF_SS_RTA 4
// primary status fields
`define UPEF_PS_SSERR 0
`define UPEF_PS_MDPE 1
`define UPEF_PS_RMA 2
// uncorrectable error classes (status, mask, severity, pointer code)
`define UPEF_UE_UNCORRECTABLE_DATA_ERROR_FLAG 0
`define UPEF_UE_PERR 1
`define UPEF_UE_UADD 2
`define UPEF_UE_W 3
// the same classes as two-bit pointer codes
`define UPEF_CODE_UNCORRECTABLE_DATA_ERROR_FLAG 2'h0
`define UPEF_CODE_PERR 2'h1
`define UPEF_CODE_UADD 2'h2
`define UPEF_UMASK_RST 3'h0
`define UPEF_USEV_RST 3'h0
// first error pointer: valid bit and code field
`define UPEF_PTR_VALID 2
// device status fields
`define UPEF_DS_FTL 0
`define UPEF_DS_NFTL 1
// interrupt event bits
`define UPEF_IRQ_ERR 0
`define UPEF_IRQ_MSG 1
`define UPEF_IRQ_W 2
`define UPEF_ALL_ONES 32'hFFFFFFFF
`endif

/* File: design/upef_top.v */
// upstream pci error forwarding: parity, abort translation, logging and error messages
// Notes on behaviour
// - bad-parity forwarded writes go out poisoned
// - UR on read: abort or all-ones by mode
// - UR on io write: abort or normal by mode
// - completer abort always gives target abort
// - write data error sets detected parity flag
// - non-posted error, response on: discard, assert perr
// - non-posted error, response off: poison, no perr
// - posted error: perr and master flag when enabled
// - write data errors set uncorrectable data flag
// - unmasked first error logs header and pointer
// - unmasked error sends message by severity
// - message with serr enable sets system flag
// - handled error sets fatal or nonfatal detected
// - perr on clean read: continue, set flag
// - perr on poisoned read: no message
// - address parity, response on: abort, discard, flags set
// - any UR completion sets received master abort
// - mode comes from control register bit
`timescale 1ns/1ns
`include "upef_defs.vh"
module upef_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  wr_err_valid,
  wr_err_posted,
  wr_hdr,
  fwd_valid,
  fwd_poison,
  fwd_discard,
  perr_out_n,
  perr_oe_n,
  perr_in_n,
  rdcpl_active,
  rdcpl_poisoned,
  rdcpl_hdr,
  addr_err_valid,
  addr_hdr,
  cpl_valid,
  cpl_status_ur,
  cpl_status_ca,
  cpl_is_write,
  cpl_hdr,
  resp_valid,
  resp_target_abort,
  resp_all_ones,
  resp_data,
  msg_valid,
  msg_fatal,
  irq
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  // secondary-side write with a data parity error, one cycle pulse
  input wire wr_err_valid;
  input wire wr_err_posted;
  input wire [31:0] wr_hdr;
  output reg fwd_valid;
  output reg fwd_poison;
  output reg fwd_discard;
  // perr pin as three signals; oe low while driving
  output reg perr_out_n;
  output reg perr_oe_n;
  input wire perr_in_n;
  input wire rdcpl_active;
  input wire rdcpl_poisoned;
  input wire [31:0] rdcpl_hdr;
  input wire addr_err_valid;
  input wire [31:0] addr_hdr;
  input wire cpl_valid;
  input wire cpl_status_ur;
  input wire cpl_status_ca;
  input wire cpl_is_write;
  input wire [31:0] cpl_hdr;
  output reg resp_valid;
  output reg resp_target_abort;
  output reg resp_all_ones;
  output reg [31:0] resp_data;
  output reg msg_valid;
  output reg msg_fatal;
  output wire irq;

  reg [4:0] ctrl_q;
  reg [4:0] sec_stat_q;
  reg [2:0] pri_stat_q;
  reg [`UPEF_UE_W-1:0] unc_stat_q;
  reg [`UPEF_UE_W-1:0] unc_mask_q;
  reg [`UPEF_UE_W-1:0] unc_sev_q;
  reg [2:0] first_error_pointer_q;
  reg [31:0] hdr_log_q;
  reg [1:0] dev_stat_q;
  reg [`UPEF_IRQ_W-1:0] irq_stat_q;
  reg [`UPEF_IRQ_W-1:0] irq_mask_q;
  reg [2:0] perr_sync_q;
  reg perr_level_q;

  wire perespon = ctrl_q[`UPEF_CTRL_PERESP];
  wire ma_mode = ctrl_q[`UPEF_CTRL_MAMODE];
  wire system_error_report_enable = ctrl_q[`UPEF_CTRL_SYSTEM_ERROR_REPORT_ENABLE];

  // perr pin from the pci master is asynchronous; the level follows only once perr_sync_q[1] and perr_sync_q[2] agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_sync_q <= 3'h7;
      perr_level_q <= 1'b0;
    end else begin
      perr_sync_q <= {perr_sync_q[1:0], perr_in_n};
      if (perr_sync_q[1] == perr_sync_q[2])
        perr_level_q <= ~perr_sync_q[2];
    end
  end
  reg perr_prev_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      perr_prev_q <= 1'b0;
    else
      perr_prev_q <= perr_level_q;
  end
  // counted once per assertion while a read completion is being returned
  wire rd_perr = perr_level_q & ~perr_prev_q & rdcpl_active;

  // apb access, zero wait states
  wire wr_acc = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a[1:0] == 2'h0) && (a <= `UPEF_IRQ_MASK_OFS);
    end
  endfunction
  assign pslverr = psel & penable & ~addr_known(paddr);

  function wr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      wr_hit = (a == ofs);
    end
  endfunction

  // which error class fires this cycle; only one class is logged per cycle
  reg ev_any;
  reg [1:0] ev_code;
  reg [31:0] ev_hdr;
  reg ev_msg_ok;
  reg ud_err;
  always @* begin
    ud_err = wr_err_valid;
    ev_any = 1'b0;
    ev_code = 2'h0;
    ev_hdr = 32'h0;
    ev_msg_ok = 1'b1;
    if (addr_err_valid && perespon) begin
      ev_any = 1'b1;
      ev_code = `UPEF_CODE_UADD;
      ev_hdr = addr_hdr;
    end else if (ud_err) begin
      ev_any = 1'b1;
      ev_code = `UPEF_CODE_UNCORRECTABLE_DATA_ERROR_FLAG;
      ev_hdr = wr_hdr;
    end else if (rd_perr) begin
      ev_any = 1'b1;
      ev_code = `UPEF_CODE_PERR;
      ev_hdr = rdcpl_hdr;
      ev_msg_ok = ~rdcpl_poisoned;
    end
  end

  wire ev_unmasked = ev_any & ~unc_mask_q[ev_code];
  wire ev_fatal = unc_sev_q[ev_code];
  wire rep_en = system_error_report_enable | (ev_fatal ? ctrl_q[`UPEF_CTRL_FTL_EN] : ctrl_q[`UPEF_CTRL_NFTL_EN]);
  wire send_msg = ev_unmasked & ev_msg_ok & rep_en;
  wire log_hdr = ev_unmasked & ~first_error_pointer_q[`UPEF_PTR_VALID];
  wire ur_evt = cpl_valid & cpl_status_ur;
  wire cpl_ta = cpl_valid & (cpl_status_ca | (cpl_status_ur & ma_mode));
  wire addr_abort = addr_err_valid & perespon;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `UPEF_CTRL_RST;
      unc_mask_q <= `UPEF_UMASK_RST;
      unc_sev_q <= `UPEF_USEV_RST;
      irq_mask_q <= {`UPEF_IRQ_W{1'b0}};
    end else if (wr_acc) begin
      if (wr_hit(paddr, `UPEF_CTRL_OFS))
        ctrl_q <= pwdata[4:0];
      else if (wr_hit(paddr, `UPEF_UNC_MASK_OFS))
        unc_mask_q <= pwdata[`UPEF_UE_W-1:0];
      else if (wr_hit(paddr, `UPEF_UNC_SEV_OFS))
        unc_sev_q <= pwdata[`UPEF_UE_W-1:0];
      else if (wr_hit(paddr, `UPEF_IRQ_MASK_OFS))
        irq_mask_q <= pwdata[`UPEF_IRQ_W-1:0];
    end
  end

  // write-one-to-clear status; a hardware set in the same cycle wins
  function [4:0] w1c;
    input [4:0] cur;
    input [4:0] set;
    input hit;
    input [4:0] data;
    begin
      w1c = (cur & ~(hit ? data : 5'h00)) | set;
    end
  endfunction

  reg [4:0] sec_set;
  reg [4:0] pri_set;
  reg [4:0] unc_set;
  reg [4:0] dev_set;
  always @* begin
    sec_set = 5'h00;
    pri_set = 5'h00;
    unc_set = 5'h00;
    dev_set = 5'h00;
    sec_set[`UPEF_SS_DPE] = ud_err | addr_err_valid;
    sec_set[`UPEF_SS_MDP] = ud_err & wr_err_posted & perespon;
    sec_set[`UPEF_SS_STA] = (addr_err_valid & perespon) |
      (cpl_valid & (cpl_status_ca | (cpl_status_ur & ma_mode)));
    sec_set[`UPEF_SS_RMA] = ur_evt;
    sec_set[`UPEF_SS_RTA] = cpl_valid & cpl_status_ca;
    pri_set[`UPEF_PS_SSERR] = send_msg & system_error_report_enable;
    pri_set[`UPEF_PS_MDPE] = ud_err & ~wr_err_posted & perespon;
    pri_set[`UPEF_PS_RMA] = ur_evt;
    unc_set[`UPEF_UE_UNCORRECTABLE_DATA_ERROR_FLAG] = ud_err;
    unc_set[`UPEF_UE_PERR] = rd_perr;
    unc_set[`UPEF_UE_UADD] = addr_err_valid & perespon;
    dev_set[`UPEF_DS_FTL] = ev_any & ev_fatal;
    dev_set[`UPEF_DS_NFTL] = ev_any & ~ev_fatal;
  end

  wire [4:0] sec_nx = w1c(sec_stat_q, sec_set, wr_acc & wr_hit(paddr, `UPEF_SEC_STAT_OFS),
    pwdata[4:0]);
  wire [4:0] pri_nx = w1c({2'h0, pri_stat_q}, pri_set,
    wr_acc & wr_hit(paddr, `UPEF_PRI_STAT_OFS), pwdata[4:0]);
  wire [4:0] unc_nx = w1c({2'h0, unc_stat_q}, unc_set,
    wr_acc & wr_hit(paddr, `UPEF_UNC_STAT_OFS), pwdata[4:0]);
  wire [4:0] dev_nx = w1c({3'h0, dev_stat_q}, dev_set,
    wr_acc & wr_hit(paddr, `UPEF_DEV_STAT_OFS), pwdata[4:0]);
  wire [4:0] irq_set = {3'h0, send_msg, ev_any};
  wire [4:0] irq_nx = w1c({3'h0, irq_stat_q}, irq_set,
    wr_acc & wr_hit(paddr, `UPEF_IRQ_STAT_OFS), pwdata[4:0]);
  wire ptr_clr = wr_acc & wr_hit(paddr, `UPEF_FIRST_ERROR_POINTER_OFS) & pwdata[`UPEF_PTR_VALID];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_stat_q <= 5'h00;
      pri_stat_q <= 3'h0;
      unc_stat_q <= {`UPEF_UE_W{1'b0}};
      dev_stat_q <= 2'h0;
      irq_stat_q <= {`UPEF_IRQ_W{1'b0}};
      first_error_pointer_q <= 3'h0;
      hdr_log_q <= 32'h0;
    end else begin
      sec_stat_q <= sec_nx;
      pri_stat_q <= pri_nx[2:0];
      unc_stat_q <= unc_nx[`UPEF_UE_W-1:0];
      dev_stat_q <= dev_nx[1:0];
      irq_stat_q <= irq_nx[`UPEF_IRQ_W-1:0];
      // a new capture beats a simultaneous release of the pointer
      if (log_hdr) begin
        first_error_pointer_q <= {1'b1, ev_code};
        hdr_log_q <= ev_hdr;
      end else if (ptr_clr) begin
        first_error_pointer_q <= 3'h0;
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // forwarding decision and pin/completion responses, one cycle after the event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid <= 1'b0;
      fwd_poison <= 1'b0;
      fwd_discard <= 1'b0;
      perr_out_n <= 1'b1;
      perr_oe_n <= 1'b1;
      resp_valid <= 1'b0;
      resp_target_abort <= 1'b0;
      resp_all_ones <= 1'b0;
      resp_data <= 32'h0;
      msg_valid <= 1'b0;
      msg_fatal <= 1'b0;
    end else begin
      fwd_valid <= 1'b0;
      fwd_poison <= 1'b0;
      fwd_discard <= 1'b0;
      perr_out_n <= 1'b1;
      perr_oe_n <= 1'b1;
      if (addr_err_valid && perespon) begin
        fwd_discard <= 1'b1;
      end else if (wr_err_valid) begin
        if (!wr_err_posted && perespon) begin
          fwd_discard <= 1'b1;
          perr_out_n <= 1'b0;
          perr_oe_n <= 1'b0;
        end else begin
          fwd_valid <= 1'b1;
          fwd_poison <= 1'b1;
          if (perespon) begin
            perr_out_n <= 1'b0;
            perr_oe_n <= 1'b0;
          end
        end
      end
      // an address parity error with parity response on ends the pci transaction with target abort as well
      resp_valid <= (cpl_valid & (cpl_status_ur | cpl_status_ca)) | addr_abort;
      resp_target_abort <= cpl_ta | addr_abort;
      resp_all_ones <= ur_evt & ~ma_mode & ~cpl_is_write;
      resp_data <= (ur_evt & ~ma_mode & ~cpl_is_write) ? `UPEF_ALL_ONES : 32'h0;
      msg_valid <= send_msg;
      msg_fatal <= send_msg & ev_fatal;
    end
  end

  // read mux; unmapped addresses read as zero
  function [31:0] rd_word;
    input [11:0] a;
    begin
      rd_word = 32'h0;
      if (a == `UPEF_CTRL_OFS)
        rd_word = {27'h0, ctrl_q};
      else if (a == `UPEF_SEC_STAT_OFS)
        rd_word = {27'h0, sec_stat_q};
      else if (a == `UPEF_PRI_STAT_OFS)
        rd_word = {29'h0, pri_stat_q};
      else if (a == `UPEF_UNC_STAT_OFS)
        rd_word = {29'h0, unc_stat_q};
      else if (a == `UPEF_UNC_MASK_OFS)
        rd_word = {29'h0, unc_mask_q};
      else if (a == `UPEF_UNC_SEV_OFS)
        rd_word = {29'h0, unc_sev_q};
      else if (a == `UPEF_FIRST_ERROR_POINTER_OFS)
        rd_word = {29'h0, first_error_pointer_q};
      else if (a == `UPEF_HDR_LOG_OFS)
        rd_word = hdr_log_q;
      else if (a == `UPEF_DEV_STAT_OFS)
        rd_word = {30'h0, dev_stat_q};
      else if (a == `UPEF_IRQ_STAT_OFS)
        rd_word = {30'h0, irq_stat_q};
      else if (a == `UPEF_IRQ_MASK_OFS)
        rd_word = {30'h0, irq_mask_q};
    end
  endfunction

  // read data leaves a flop yet keeps zero wait states: it is taken in the setup
  // cycle, so a flag set during that one cycle only shows on the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_setup)
      prdata <= rd_word(paddr);
    else
      prdata <= 32'h0;
  end
endmodule

/* File: tb/upef_pci_master.sv */
// pci master model returning parity errors on a delayed read completion
`timescale 1ns/1ns
module upef_pci_master (
  input wire logic pclk,
  input wire logic start,
  input wire logic poison,
  output logic rdcpl_active,
  output logic rdcpl_poisoned,
  output logic perr_in_n
);
  int n = 0;
  always @(posedge pclk) begin
    if (start)
      n <= 12;
    else if (n > 0)
      n <= n - 1;
  end
  assign rdcpl_active = n > 0;
  assign rdcpl_poisoned = (n > 0) && poison;
  // four data phases of perr, long enough for the pin synchroniser; pull-up level otherwise
  assign perr_in_n = !(n > 4 && n < 9);
endmodule

/* File: tb/upef_checker_assertions.sv */
// concurrent checks on the event and apb ports of the error forwarding block
`timescale 1ns/1ns
module upef_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire wr_err_valid,
  input wire wr_err_posted,
  input wire addr_err_valid,
  input wire cpl_valid,
  input wire cpl_status_ur,
  input wire cpl_status_ca,
  input wire cpl_is_write,
  input wire fwd_valid,
  input wire fwd_poison,
  input wire fwd_discard,
  input wire perr_out_n,
  input wire perr_oe_n,
  input wire resp_valid,
  input wire resp_target_abort,
  input wire resp_all_ones,
  input wire [31:0] resp_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_drop; fwd_discard && !fwd_valid && !perr_out_n && !perr_oe_n; endsequence
  sequence s_pois; fwd_valid && fwd_poison && !fwd_discard && perr_oe_n; endsequence
  wire ur_only = cpl_valid && cpl_status_ur && !cpl_status_ca;
  property p_np; wr_err_valid && !wr_err_posted |=> s_drop or s_pois; endproperty
  property p_post; wr_err_valid && wr_err_posted |=> fwd_valid && fwd_poison; endproperty
  property p_ca; cpl_valid && cpl_status_ca |=> resp_valid && resp_target_abort; endproperty
  property p_urw; ur_only && cpl_is_write |=> resp_valid && !resp_all_ones; endproperty
  property p_urr;
    ur_only && !cpl_is_write |=> resp_valid && (resp_target_abort ^ resp_all_ones);
  endproperty
  property p_ones; resp_all_ones |-> resp_data == 32'hFFFFFFFF; endproperty
  property p_addr; addr_err_valid && !wr_err_valid |=> !fwd_valid && !fwd_poison; endproperty
  property p_pulse; !perr_oe_n |-> $past(wr_err_valid) && !perr_out_n; endproperty
  property p_rdy; psel && penable |-> pready; endproperty
  a_np: assert property (p_np) else $error("non-posted data error mishandled");
  a_post: assert property (p_post) else $error("posted error not poisoned");
  a_ca: assert property (p_ca) else $error("completer abort not aborted");
  a_urw: assert property (p_urw) else $error("io write returned data");
  a_urr: assert property (p_urr) else $error("read answer wrong");
  a_ones: assert property (p_ones) else $error("all-ones data wrong");
  a_addr: assert property (p_addr) else $error("address error forwarded");
  a_pulse: assert property (p_pulse) else $error("perr driven without write error");
  a_rdy: assert property (p_rdy) else $error("apb access stalled");
endmodule
bind upef_top upef_checker i_upef_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .wr_err_valid(wr_err_valid),
  .wr_err_posted(wr_err_posted), .addr_err_valid(addr_err_valid), .cpl_valid(cpl_valid),
  .cpl_status_ur(cpl_status_ur), .cpl_status_ca(cpl_status_ca), .cpl_is_write(cpl_is_write),
  .fwd_valid(fwd_valid), .fwd_poison(fwd_poison), .fwd_discard(fwd_discard),
  .perr_out_n(perr_out_n), .perr_oe_n(perr_oe_n), .resp_valid(resp_valid),
  .resp_target_abort(resp_target_abort), .resp_all_ones(resp_all_ones), .resp_data(resp_data));

/* File: tb/tb_top.sv */
// self-checking bench for the upstream error forwarding block
`timescale 1ns/1ns
`include "upef_defs.vh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, err, rd_go, rd_pois;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, hdr;
  wire [31:0] prdata, resp_data;
  wire pready, pslverr, fwd_valid, fwd_poison, fwd_discard, perr_out_n, perr_oe_n, irq;
  wire resp_valid, resp_target_abort, resp_all_ones, msg_valid, msg_fatal, m_perr_n;
  wire rdcpl_active, rdcpl_poisoned;
  logic wr_err_valid, wr_err_posted, addr_err_valid, cpl_valid, ur, ca, cpl_is_write;
  logic [9:0] o;
  logic [31:0] rdat;
  int bad_count = 0, checked = 0, cyc = 0, msgs = 0;
  // shared perr wire: either party pulls low, pull-up otherwise
  wire perr_n = (perr_oe_n ? 1'b1 : perr_out_n) & m_perr_n;
  upef_top i_upef_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_err_valid(wr_err_valid), .wr_err_posted(wr_err_posted),
    .wr_hdr(hdr), .fwd_valid(fwd_valid), .fwd_poison(fwd_poison), .fwd_discard(fwd_discard),
    .perr_out_n(perr_out_n), .perr_oe_n(perr_oe_n), .perr_in_n(perr_n),
    .rdcpl_active(rdcpl_active), .rdcpl_poisoned(rdcpl_poisoned), .rdcpl_hdr(hdr),
    .addr_err_valid(addr_err_valid), .addr_hdr(hdr), .cpl_valid(cpl_valid),
    .cpl_status_ur(ur), .cpl_status_ca(ca), .cpl_is_write(cpl_is_write), .cpl_hdr(hdr),
    .resp_valid(resp_valid), .resp_target_abort(resp_target_abort),
    .resp_all_ones(resp_all_ones), .resp_data(resp_data), .msg_valid(msg_valid),
    .msg_fatal(msg_fatal), .irq(irq));
  upef_pci_master i_upef_pci_master (.pclk(pclk), .start(rd_go), .poison(rd_pois),
    .rdcpl_active(rdcpl_active), .rdcpl_poisoned(rdcpl_poisoned), .perr_in_n(m_perr_n));
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (msg_valid === 1'b1)
      msgs <= msgs + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk_reg(input [31:0] g, input [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t reg %h exp %h", $time, g, e);
    end
  endtask
  task chk_ev(input [9:0] e);
    checked++;
    if (o !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t outputs %b exp %b", $time, o, e);
    end
  endtask
  task rst;
    presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
  endtask
  task apb(input logic w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdx(input [11:0] a, input [31:0] e);
    apb(0, a, 0);
    chk_reg(rd, e);
  endtask
  // output snapshot order: fwd v/p/d, perr out/oe, resp v/ta/ones, msg v/fatal
  task ev(input int k);
    @(posedge pclk);
    wr_err_valid <= k == 0;
    addr_err_valid <= k == 1;
    cpl_valid <= k == 2;
    @(posedge pclk);
    {wr_err_valid, addr_err_valid, cpl_valid} <= 3'b000;
    #1 o = {fwd_valid, fwd_poison, fwd_discard, perr_out_n, perr_oe_n, resp_valid,
      resp_target_abort, resp_all_ones, msg_valid, msg_fatal};
    rdat = resp_data;
  endtask
  task t_regs;
    rst();
    rdx(`UPEF_SEC_STAT_OFS, 0);
    apb(1, `UPEF_CTRL_OFS, 32'h0000001F);
    rdx(`UPEF_CTRL_OFS, 32'h0000001F);
    apb(1, `UPEF_HDR_LOG_OFS, 32'h00000055);
    rdx(`UPEF_HDR_LOG_OFS, 0);
    rdx(12'h0FC, 0);
    chk_reg({31'h0, err}, 32'h1);
  endtask
  task t_np;
    rst();
    apb(1, `UPEF_CTRL_OFS, 32'h00000015);
    apb(1, `UPEF_IRQ_MASK_OFS, 32'h00000001);
    wr_err_posted <= 0;
    ev(0);
    chk_ev(10'b0010000010);
    rdx(`UPEF_SEC_STAT_OFS, 32'h1);
    rdx(`UPEF_PRI_STAT_OFS, 32'h3);
    rdx(`UPEF_UNC_STAT_OFS, 32'h1);
    rdx(`UPEF_DEV_STAT_OFS, 32'h2);
    chk_reg({31'h0, irq}, 32'h1);
    apb(1, `UPEF_IRQ_STAT_OFS, 32'h00000001);
    @(posedge pclk);
    chk_reg({31'h0, irq}, 32'h0);
    hdr <= 32'h5A5A0002;
    wr_err_posted <= 1;
    ev(0);
    chk_ev(10'b1100000010);
    rdx(`UPEF_SEC_STAT_OFS, 32'h3);
    rdx(`UPEF_FIRST_ERROR_POINTER_OFS, 32'h4);
    rdx(`UPEF_HDR_LOG_OFS, 32'hA5A50001);
    hdr <= 32'hA5A50001;
  endtask
  task t_mask;
    rst();
    apb(1, `UPEF_CTRL_OFS, 32'h00000018);
    apb(1, `UPEF_UNC_MASK_OFS, 32'h00000001);
    apb(1, `UPEF_UNC_SEV_OFS, 32'h00000001);
    wr_err_posted <= 0;
    ev(0);
    chk_ev(10'b1101100000);
    rdx(`UPEF_FIRST_ERROR_POINTER_OFS, 0);
    apb(1, `UPEF_UNC_MASK_OFS, 32'h00000000);
    ev(0);
    chk_ev(10'b1101100011);
    rdx(`UPEF_PRI_STAT_OFS, 0);
    rdx(`UPEF_DEV_STAT_OFS, 32'h1);
  endtask
  task t_cpl;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) begin
        rst();
        apb(1, `UPEF_CTRL_OFS, m << 1);
        ur <= k < 2;
        ca <= k == 2;
        cpl_is_write <= k == 1;
        ev(2);
        chk_ev({5'b00011, 1'b1, k == 2 || m == 1, k == 0 && m == 0, 2'b00});
        chk_reg(rdat, (k == 0 && m == 0) ? `UPEF_ALL_ONES : 32'h0);
        rdx(`UPEF_PRI_STAT_OFS, k < 2 ? 32'h4 : 32'h0);
      end
    end
    {ur, ca} <= 2'b00;
  endtask
  task t_addr;
    rst();
    apb(1, `UPEF_CTRL_OFS, 32'h00000001);
    ev(1);
    chk_ev(10'b0011111000);
    rdx(`UPEF_SEC_STAT_OFS, 32'h5);
    rdx(`UPEF_UNC_STAT_OFS, 32'h4);
    rdx(`UPEF_FIRST_ERROR_POINTER_OFS, 32'h6);
    rst();
    ev(1);
    chk_ev(10'b0001100000);
    rdx(`UPEF_SEC_STAT_OFS, 32'h1);
  endtask
  task t_rd(input logic p);
    int m0;
    rst();
    m0 = msgs;
    apb(1, `UPEF_CTRL_OFS, 32'h00000015);
    rd_pois <= p;
    rd_go <= 1;
    @(posedge pclk);
    rd_go <= 0;
    repeat (16) @(posedge pclk);
    rdx(`UPEF_UNC_STAT_OFS, 32'h2);
    rdx(`UPEF_FIRST_ERROR_POINTER_OFS, 32'h5);
    chk_reg(msgs - m0, p ? 0 : 1);
    rdx(`UPEF_PRI_STAT_OFS, p ? 32'h0 : 32'h1);
  endtask
  initial begin
    {psel, penable, pwrite, wr_err_valid, wr_err_posted, addr_err_valid, cpl_valid} = 0;
    {ur, ca, cpl_is_write, rd_go, rd_pois, presetn} = 0;
    paddr = 0;
    pwdata = 0;
    hdr = 32'hA5A50001;
    t_regs();
    t_np();
    t_mask();
    t_cpl();
    t_addr();
    t_rd(0);
    t_rd(1);
    give_verdict();
  end
endmodule
